// *** logic/mwdt_top.sv ***
// Minute watchdog core: registers, trigger sources and down counter
`timescale 1ns/10ps
`include "mwdt_defines.svh"
module mwdt_top #(
    parameter logic [35:0] TICK_CYCLES = 36'(64'(`MWDT_MINUTE_S) * 64'(`MWDT_CLOCK_HZ))
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire mwdt_pkg::mwdt_byte_t regAddr,
    input wire mwdt_pkg::mwdt_byte_t regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output mwdt_pkg::mwdt_byte_t regRdData,
    input wire logic serOneIrq,
    input wire logic serTwoIrq,
    input wire logic mouseIrq,
    input wire logic keyboardIrq,
    input wire logic vddPowerUpReset,
    output logic watchdogOn,
    output logic watchdogExpired,
    output mwdt_pkg::mwdt_byte_t minutesLeft
);
    import mwdt_pkg::*;

    // A literal cannot be bit-selected, so the reset byte gets a name first
    localparam mwdt_byte_t RST_CONTROL = `MWDT_RST_CONTROL;
    mwdt_state_t st_r;
    mwdt_state_t st_nxt;
    mwdt_tick_if tk ();

    logic controlWr;
    logic reloadWr;
    logic sourcesWr;
    logic swHit;
    logic irqHit;
    logic restart;
    mwdt_lanes_t laneIn;

    function automatic logic isReg(input mwdt_byte_t addr, input mwdt_byte_t offset);
        isReg = (addr == offset);
    endfunction : isReg

    assign laneIn = {vddPowerUpReset, serTwoIrq, serOneIrq, mouseIrq, keyboardIrq};
    assign controlWr = regWr && isReg(regAddr, `MWDT_OFF_CONTROL);
    assign reloadWr = regWr && isReg(regAddr, `MWDT_OFF_RELOAD);
    assign sourcesWr = regWr && isReg(regAddr, `MWDT_OFF_SOURCES);
    // Software retrigger counts only when its source is allowed
    assign swHit = controlWr && regWrData[`MWDT_CTL_RETRIGGER_BIT]
        && st_r.sources[`MWDT_SRC_SW_BIT];
    // Active IRQ level holds the count at reload for as long as it stays high
    assign irqHit = |(st_r.filt[`MWDT_IRQ_LANES-1:0]
        & st_r.sources[`MWDT_IRQ_LANES-1:0]);
    assign restart = swHit || irqHit;

    assign tk.run = st_r.on;
    assign tk.restart = restart;

    mwdt_prescaler #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .tk(tk.timebase)
    );

    always_comb begin
        st_nxt = st_r;
        // Three-flop synchronisers; a change counts once stages two and three agree
        st_nxt.sync1 = laneIn;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        for (int i = 0; i <= `MWDT_VDD_LANE; i++) begin
            if (st_r.sync2[i] == st_r.sync3[i]) begin
                st_nxt.filt[i] = st_r.sync2[i];
            end
        end

        if (controlWr && regWrData[`MWDT_CTL_ON_BIT]) begin
            st_nxt.on = 1'b1;
        end
        // Software cannot clear the enable; main power-up reset does, and wins
        if (st_r.filt[`MWDT_VDD_LANE]) begin
            st_nxt.on = 1'b0;
        end
        if (reloadWr) begin
            st_nxt.reload = regWrData;
        end
        if (sourcesWr) begin
            st_nxt.sources = regWrData & `MWDT_SRC_MASK;
        end

        if (!st_nxt.on) begin
            st_nxt.expired = 1'b0;
        end else if (!st_r.on || restart) begin
            st_nxt.count = st_r.reload;
            st_nxt.expired = 1'b0;
        end else if (tk.tick && (st_r.count != `MWDT_ZERO_BYTE)) begin
            st_nxt.count = st_r.count - `MWDT_ONE_BYTE;
            st_nxt.expired = (st_r.count == `MWDT_ONE_BYTE);
        end

        st_nxt.rdData = `MWDT_ZERO_BYTE;
        if (regRd) begin
            if (isReg(regAddr, `MWDT_OFF_CONTROL)) begin
                // Retrigger bit is never stored, so it reads zero
                st_nxt.rdData[`MWDT_CTL_ON_BIT] = st_r.on;
            end else if (isReg(regAddr, `MWDT_OFF_RELOAD)) begin
                st_nxt.rdData = st_r.reload;
            end else if (isReg(regAddr, `MWDT_OFF_SOURCES)) begin
                st_nxt.rdData = st_r.sources;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.on <= RST_CONTROL[`MWDT_CTL_ON_BIT];
            st_r.reload <= `MWDT_RST_RELOAD;
            st_r.sources <= `MWDT_RST_SOURCES;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign watchdogOn = st_r.on;
    assign watchdogExpired = st_r.expired;
    assign minutesLeft = st_r.count;

    // Checks of the watchdog behaviour

    sequence s_control_write_one(int bitPos);
        controlWr && regWrData[bitPos];
    endsequence

    sequence s_reload_seen;
        st_r.count == $past(st_r.reload);
    endsequence

    property p_sw_retrigger;
        @(posedge clock) disable iff (!rst_n)
        s_control_write_one(`MWDT_CTL_RETRIGGER_BIT) and
            (st_r.sources[`MWDT_SRC_SW_BIT] && st_r.on && !st_r.filt[`MWDT_VDD_LANE])
        |=> s_reload_seen;
    endproperty
    a_sw_retrigger: assert property (p_sw_retrigger)
        else $error("software retrigger did not reload the count");

    property p_retrigger_reads_zero;
        @(posedge clock) disable iff (!rst_n)
        regRd && isReg(regAddr, `MWDT_OFF_CONTROL)
        |=> regRdData[`MWDT_CTL_RETRIGGER_BIT] == 1'b0
            && regRdData[`MWDT_CTL_ON_BIT] == $past(st_r.on);
    endproperty
    a_retrigger_reads_zero: assert property (p_retrigger_reads_zero)
        else $error("control read returned a wrong value");

    property p_write_one_sets;
        @(posedge clock) disable iff (!rst_n)
        s_control_write_one(`MWDT_CTL_ON_BIT) and !st_r.filt[`MWDT_VDD_LANE]
        |=> watchdogOn ##1 watchdogOn || $past(st_r.filt[`MWDT_VDD_LANE]);
    endproperty
    a_write_one_sets: assert property (p_write_one_sets)
        else $error("enable write did not set the enable");

    property p_on_sticky;
        @(posedge clock) disable iff (!rst_n)
        st_r.on && !st_r.filt[`MWDT_VDD_LANE] |=> st_r.on;
    endproperty
    a_on_sticky: assert property (p_on_sticky)
        else $error("enable cleared without a power-up reset");

    property p_vdd_clears_on;
        @(posedge clock) disable iff (!rst_n)
        st_r.filt[`MWDT_VDD_LANE] |=> !st_r.on && !watchdogExpired;
    endproperty
    a_vdd_clears_on: assert property (p_vdd_clears_on)
        else $error("power-up reset left the watchdog enabled");

    property p_sw_gated;
        @(posedge clock) disable iff (!rst_n)
        controlWr && !st_r.sources[`MWDT_SRC_SW_BIT] && !irqHit && !tk.tick && st_r.on
            && !st_r.filt[`MWDT_VDD_LANE]
        |=> $stable(st_r.count);
    endproperty
    a_sw_gated: assert property (p_sw_gated)
        else $error("disallowed software retrigger changed the count");

    property p_irq_restart;
        @(posedge clock) disable iff (!rst_n)
        irqHit && st_r.on && !st_r.filt[`MWDT_VDD_LANE] |=> s_reload_seen;
    endproperty
    a_irq_restart: assert property (p_irq_restart)
        else $error("enabled IRQ did not restart the count");

    property p_irq_ignored;
        @(posedge clock) disable iff (!rst_n)
        st_r.sources[`MWDT_IRQ_LANES-1:0] == 4'h0 && !swHit && !tk.tick && st_r.on
            && !st_r.filt[`MWDT_VDD_LANE]
        |=> $stable(st_r.count);
    endproperty
    a_irq_ignored: assert property (p_irq_ignored)
        else $error("count changed with all sources disallowed");

    property p_reload_read;
        @(posedge clock) disable iff (!rst_n)
        regRd && isReg(regAddr, `MWDT_OFF_RELOAD) |=> regRdData == $past(st_r.reload);
    endproperty
    a_reload_read: assert property (p_reload_read)
        else $error("reload read returned a wrong value");

    property p_load_on_enable;
        @(posedge clock) disable iff (!rst_n)
        $rose(st_r.on) |-> st_r.count == $past(st_r.reload) && !watchdogExpired;
    endproperty
    a_load_on_enable: assert property (p_load_on_enable)
        else $error("enable did not load the counter");

    sequence s_last_minute;
        tk.tick && st_r.on && st_r.count == `MWDT_ONE_BYTE && !restart
            && !st_r.filt[`MWDT_VDD_LANE];
    endsequence

    property p_expiry;
        @(posedge clock) disable iff (!rst_n)
        s_last_minute |=> minutesLeft == `MWDT_ZERO_BYTE && watchdogExpired;
    endproperty
    a_expiry: assert property (p_expiry)
        else $error("expiry not flagged at zero");

    property p_decrement;
        @(posedge clock) disable iff (!rst_n)
        tk.tick && st_r.on && st_r.count > `MWDT_ONE_BYTE && !restart
            && !st_r.filt[`MWDT_VDD_LANE]
        |=> st_r.count == $past(st_r.count) - `MWDT_ONE_BYTE && !watchdogExpired;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("minute tick did not decrement the count");

    property p_no_tick_when_off;
        @(posedge clock) disable iff (!rst_n)
        !st_r.on |=> !tk.tick;
    endproperty
    a_no_tick_when_off: assert property (p_no_tick_when_off)
        else $error("time base ran while disabled");

    sequence s_lane_hit(int lane);
        st_r.filt[lane] && st_r.sources[lane] && st_r.on && !st_r.filt[`MWDT_VDD_LANE];
    endsequence

    property p_ser_two_restart;
        @(posedge clock) disable iff (!rst_n)
        s_lane_hit(`MWDT_SRC_SER2_BIT) |=> s_reload_seen;
    endproperty
    a_ser_two_restart: assert property (p_ser_two_restart)
        else $error("serial two IRQ did not restart the count");

    property p_ser_one_restart;
        @(posedge clock) disable iff (!rst_n)
        s_lane_hit(`MWDT_SRC_SER1_BIT) |=> s_reload_seen;
    endproperty
    a_ser_one_restart: assert property (p_ser_one_restart)
        else $error("serial one IRQ did not restart the count");

    property p_mouse_restart;
        @(posedge clock) disable iff (!rst_n)
        s_lane_hit(`MWDT_SRC_MOUSE_BIT) |=> s_reload_seen;
    endproperty
    a_mouse_restart: assert property (p_mouse_restart)
        else $error("mouse IRQ did not restart the count");

    property p_keyboard_restart;
        @(posedge clock) disable iff (!rst_n)
        s_lane_hit(`MWDT_SRC_KBD_BIT) |=> s_reload_seen;
    endproperty
    a_keyboard_restart: assert property (p_keyboard_restart)
        else $error("keyboard IRQ did not restart the count");

    property p_reload_write;
        @(posedge clock) disable iff (!rst_n)
        reloadWr |=> st_r.reload == $past(regWrData);
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload write did not store the value");

    property p_sources_read;
        @(posedge clock) disable iff (!rst_n)
        regRd && isReg(regAddr, `MWDT_OFF_SOURCES) |=> regRdData == $past(st_r.sources);
    endproperty
    a_sources_read: assert property (p_sources_read)
        else $error("sources read returned a wrong value");

    // Read data stand one cycle only, so a stale answer cannot be mistaken for a new one
    property p_read_idle;
        @(posedge clock) disable iff (!rst_n)
        !regRd |=> regRdData == `MWDT_ZERO_BYTE;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data not zero outside the answer cycle");

    property p_expired_holds;
        @(posedge clock) disable iff (!rst_n)
        watchdogExpired && st_r.on && !restart && !st_r.filt[`MWDT_VDD_LANE]
        |=> watchdogExpired && minutesLeft == `MWDT_ZERO_BYTE;
    endproperty
    a_expired_holds: assert property (p_expired_holds)
        else $error("expiry dropped without restart or disable");

    // Checked from the second reset edge, where the flops are surely cleared
    property p_reset_values;
        @(posedge clock)
        !rst_n ##1 !rst_n |-> !watchdogOn && !watchdogExpired
            && st_r.reload == `MWDT_RST_RELOAD && st_r.sources == `MWDT_RST_SOURCES;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("reset did not restore the register defaults");

endmodule : mwdt_top

// *** logic/mwdt_defines.svh ***
// Constants of the minute watchdog: offsets, field positions, reset values, timing
// Notes on behaviour
// - Software retrigger write restarts count from reload
// - Retrigger bit self-clears, always reads zero
// - Enable bit one activates watchdog, reset zero
// - Enable cleared only by power-up resets
// - Write one sets, write zero leaves unchanged
// - Full 8-bit reload loads the down counter
// - Reload counts minutes 1 to 255, zero reserved
// - Reset: reload one, control and sources zero
// - Source bit 7 gates software retrigger
// - Source bit 3: serial two IRQ restarts
// - Source bit 2: serial one IRQ restarts
// - Source bit 1: mouse IRQ restarts
// - Source bit 0: keyboard IRQ restarts
`ifndef MWDT_DEFINES_SVH
`define MWDT_DEFINES_SVH

`define MWDT_OFF_CONTROL 8'h10
`define MWDT_OFF_RELOAD 8'h11
`define MWDT_OFF_SOURCES 8'h12

`define MWDT_CTL_RETRIGGER_BIT 7
`define MWDT_CTL_ON_BIT 0
`define MWDT_SRC_SW_BIT 7
`define MWDT_SRC_SER2_BIT 3
`define MWDT_SRC_SER1_BIT 2
`define MWDT_SRC_MOUSE_BIT 1
`define MWDT_SRC_KBD_BIT 0
`define MWDT_SRC_MASK 8'h8F
`define MWDT_IRQ_LANES 4
`define MWDT_VDD_LANE 4

`define MWDT_RST_CONTROL 8'h00
`define MWDT_RST_RELOAD 8'h01
`define MWDT_RST_SOURCES 8'h00
`define MWDT_ZERO_BYTE 8'h00
`define MWDT_ONE_BYTE 8'h01

`define MWDT_MINUTE_S 60
`define MWDT_CLOCK_HZ 100000000

`endif

// *** logic/mwdt_pkg.sv ***
// Types shared by the minute watchdog modules
package mwdt_pkg;
    `include "mwdt_defines.svh"

    typedef logic [7:0] mwdt_byte_t;
    typedef logic [4:0] mwdt_lanes_t;

    typedef struct packed {
        mwdt_lanes_t sync1;
        mwdt_lanes_t sync2;
        mwdt_lanes_t sync3;
        mwdt_lanes_t filt;
        logic on;
        mwdt_byte_t reload;
        mwdt_byte_t sources;
        mwdt_byte_t count;
        logic expired;
        mwdt_byte_t rdData;
    } mwdt_state_t;

    typedef struct packed {
        logic [35:0] cnt;
        logic tick;
    } mwdt_tick_state_t;
endpackage : mwdt_pkg

// *** logic/mwdt_tick_if.sv ***
// Minute time base link between the watchdog core and its prescaler
`timescale 1ns/10ps
interface mwdt_tick_if;
    logic run;
    logic restart;
    logic tick;
    modport timebase (input run, input restart, output tick);
    modport user (output run, output restart, input tick);
endinterface : mwdt_tick_if

// *** logic/mwdt_prescaler.sv ***
// Minute prescaler: one-cycle tick per minute while running
`timescale 1ns/10ps
`include "mwdt_defines.svh"
module mwdt_prescaler #(
    parameter logic [35:0] TICK_CYCLES = 36'(64'(`MWDT_MINUTE_S) * 64'(`MWDT_CLOCK_HZ))
) (
    input wire logic clock,
    input wire logic rst_n,
    mwdt_tick_if.timebase tk
);
    import mwdt_pkg::*;

    mwdt_tick_state_t st_r;
    mwdt_tick_state_t st_nxt;

    // Restart clears the phase so each restart gives a full first minute
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!tk.run || tk.restart) begin
            st_nxt.cnt = 36'h0;
        end else if (st_r.cnt == TICK_CYCLES - 36'h1) begin
            st_nxt.cnt = 36'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 36'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tk.tick = st_r.tick;
endmodule : mwdt_prescaler

// *** tb/test_mwdt_top.sv ***
// Self-checking bench for the minute watchdog core
`timescale 1ns/10ps
`include "mwdt_defines.svh"
module test_mwdt_top;
    import mwdt_pkg::*;

    // Short minute so a full countdown fits in a few hundred cycles
    localparam logic [35:0] TICKS = 36'd20;
    localparam int LIMIT = 3000;

    logic clock;
    logic rst_n;
    logic regWr;
    logic regRd;
    logic vddPowerUpReset;
    logic watchdogOn;
    logic watchdogExpired;
    logic [3:0] irq;
    mwdt_byte_t regAddr;
    mwdt_byte_t regWrData;
    mwdt_byte_t regRdData;
    mwdt_byte_t minutesLeft;
    int n_errors;
    int compares;
    int cycles;
    int n;

    // Lane order follows source bits 3..0: serial two, serial one, mouse, keyboard
    mwdt_top #(.TICK_CYCLES(TICKS)) u_mwdt_top (
        .clock(clock),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData),
        .serOneIrq(irq[2]),
        .serTwoIrq(irq[3]),
        .mouseIrq(irq[1]),
        .keyboardIrq(irq[0]),
        .vddPowerUpReset(vddPowerUpReset),
        .watchdogOn(watchdogOn),
        .watchdogExpired(watchdogExpired),
        .minutesLeft(minutesLeft)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // A hung wait must still reach the report
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input mwdt_byte_t a, input mwdt_byte_t d);
        @(posedge clock);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so look there
    task automatic rd(input mwdt_byte_t a, input mwdt_byte_t exp, input string what);
        @(posedge clock);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk(what, exp, regRdData);
    endtask : rd

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        irq = 4'h0;
        vddPowerUpReset = 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(`MWDT_OFF_CONTROL, `MWDT_RST_CONTROL, "control reset");
        rd(`MWDT_OFF_RELOAD, `MWDT_RST_RELOAD, "reload reset");
        rd(`MWDT_OFF_SOURCES, `MWDT_RST_SOURCES, "sources reset");
        rd(8'h13, 8'h00, "unmapped read");
        wr(`MWDT_OFF_SOURCES, 8'hFF);
        rd(`MWDT_OFF_SOURCES, `MWDT_SRC_MASK, "sources store");
        wr(`MWDT_OFF_SOURCES, 8'h00);
        wr(`MWDT_OFF_RELOAD, 8'h03);
        rd(`MWDT_OFF_RELOAD, 8'h03, "reload store");
        wr(`MWDT_OFF_CONTROL, 8'h80);
        chk("on before enable", 8'h00, 8'(watchdogOn));
        wr(`MWDT_OFF_CONTROL, 8'h81);
        chk("on after enable", 8'h01, 8'(watchdogOn));
        chk("load on enable", 8'h03, minutesLeft);
        n = 0;
        while (watchdogExpired !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        // First tick is registered before the count takes it, hence one cycle more
        chk("cycles to expiry", 8'(3 * TICKS + 1), 8'(n));
        chk("count at expiry", 8'h00, minutesLeft);
        wr(`MWDT_OFF_CONTROL, 8'h00);
        rd(`MWDT_OFF_CONTROL, 8'h01, "enable sticky");
        wr(`MWDT_OFF_CONTROL, 8'h80);
        chk("gated retrigger", 8'h00, minutesLeft);
        wr(`MWDT_OFF_SOURCES, 8'h80);
        wr(`MWDT_OFF_CONTROL, 8'h80);
        chk("soft retrigger", 8'h03, minutesLeft);
        chk("expiry cleared", 8'h00, 8'(watchdogExpired));
        rd(`MWDT_OFF_CONTROL, 8'h01, "retrigger reads zero");
        for (int i = 0; i < 4; i++) begin
            wr(`MWDT_OFF_SOURCES, 8'h80);
            wr(`MWDT_OFF_CONTROL, 8'h80);
            wr(`MWDT_OFF_SOURCES, 8'h00);
            @(posedge clock);
            irq[i] <= 1'b1;
            repeat (20) @(posedge clock);
            #1;
            chk("irq ignored", 8'h02, minutesLeft);
            wr(`MWDT_OFF_SOURCES, 8'(1 << i));
            repeat (30) @(posedge clock);
            #1;
            chk("irq restarts", 8'h03, minutesLeft);
            @(posedge clock);
            irq[i] <= 1'b0;
        end
        @(posedge clock);
        vddPowerUpReset <= 1'b1;
        repeat (6) @(posedge clock);
        vddPowerUpReset <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        chk("main power-up clears", 8'h00, 8'(watchdogOn));
        rd(`MWDT_OFF_CONTROL, 8'h00, "control after main reset");
        wr(`MWDT_OFF_CONTROL, 8'h01);
        chk("on before standby reset", 8'h01, 8'(watchdogOn));
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(`MWDT_OFF_CONTROL, 8'h00, "standby reset clears");
        rd(`MWDT_OFF_RELOAD, `MWDT_RST_RELOAD, "reload after standby reset");
        conclude();
    end
endmodule : test_mwdt_top
